// File: rtl/vla_cfg.svh
/*
 * Constants of the luma adjust block: register offsets, field positions,
 * reset values and gain scaling figures.
 * Assumes inclusion by bare name from the package, whose macros the design modules use.
 */
// Summary of operation
// - add signed offset register to every luma sample
// - one offset unit equals one luma lsb
// - offset register resets to zero
// - control bit 7 bypasses the notch filter
// - bit 6 picks Y/C, kills notch
// - bit 5 set disables luma decimation
// - bit 4 inverts Cb/Cr order per line
// - gain is bit 2 over low byte
// - luma multiplied by 9-bit gain, low resets 0xD8
// - bits 1 and 0 are chroma gain tops
// - even and odd control copies, reset 0x20
`ifndef VLA_CFG_SVH
`define VLA_CFG_SVH

// register byte addresses
`define VLA_ADDR_LUMA_OFFSET 12'h028
`define VLA_ADDR_CTRL_EVEN 12'h02C
`define VLA_ADDR_GAIN_LOW 12'h030
`define VLA_ADDR_CTRL_ODD 12'h0AC
`define VLA_ADDR_STATUS 12'h0F0
`define VLA_ADDR_SAMPLE_COUNT 12'h0F4

// reset values
`define VLA_RST_LUMA_OFFSET 8'h00
`define VLA_RST_CTRL 8'h20
`define VLA_RST_GAIN_LOW 8'hD8

// control register bit positions
`define VLA_BIT_NOTCH_BYPASS 7
`define VLA_BIT_YC_MODE 6
`define VLA_BIT_DECIM_BYPASS 5
`define VLA_BIT_CHROMA_INVERT 4
`define VLA_BIT_RESERVED 3
`define VLA_BIT_GAIN_TOP 2
`define VLA_BIT_U_GAIN_TOP 1
`define VLA_BIT_V_GAIN_TOP 0

// status register bit positions
`define VLA_BIT_ST_CLIP_HIGH 0
`define VLA_BIT_ST_CLIP_LOW 1
`define VLA_BIT_ST_LAST_ODD 2
`define VLA_BIT_ST_BUSY 3

// gain 216 is unity: scaled = (prod * 4855 + half) >> 20
`define VLA_GAIN_RECIP 13'h12F7
`define VLA_GAIN_SHIFT 20
`define VLA_GAIN_ROUND 31'h0008_0000
`define VLA_LUMA_MAX 11'sh0FF

`endif

// File: rtl/vla_pkg.sv
/*
 * Types of the luma adjust block: per-sample input and output carriers
 * and the per-field control bundle.
 * Assumes vla_cfg.svh sits beside it on the include path.
 */
package vla_pkg;
	`include "vla_cfg.svh"

	// per-field controls that travel with every pixel
	typedef struct packed {
		logic notchBypass;
		logic ycMode;
		logic decimBypass;
		logic chromaInvert;
		logic firstIsCr;
		logic uGainTop;
		logic vGainTop;
	} vla_ctrl_t;

	// incoming luma sample
	typedef struct packed {
		logic [7:0] luma;
		logic oddField;
		logic hStartOdd;
	} vla_in_t;

	// adjusted outgoing sample
	typedef struct packed {
		logic [7:0] luma;
		logic oddField;
		vla_ctrl_t ctrl;
	} vla_pix_t;
endpackage

// File: rtl/vla_buf2.sv
/*
 * Two-entry buffer between the adjust pipeline and the sample receiver.
 * Assumes a single clock; the receiver may stall at any time.
 */
module vla_buf2
	import vla_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire vla_pix_t inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output vla_pix_t outData
);
	logic outValid_ff;
	logic spareValid_ff;
	vla_pix_t outData_ff;
	vla_pix_t spare_ff;
	logic outFree;

	// handshakes are frozen with the clock enable
	assign inReady = ce & ~spareValid_ff;
	assign outValid = ce & outValid_ff;
	assign outData = outData_ff;
	assign outFree = outReady | ~outValid_ff;

	// head register refills from spare first, then from input
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			outValid_ff <= 1'b0;
			outData_ff <= '0;
		end else if (ce && outFree) begin
			if (spareValid_ff) begin
				outValid_ff <= 1'b1;
				outData_ff <= spare_ff;
			end else begin
				outValid_ff <= inValid;
				outData_ff <= inData;
			end
		end
	end

	// spare catches a word while the head is stalled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			spareValid_ff <= 1'b0;
			spare_ff <= '0;
		end else if (ce) begin
			if (outFree) begin
				spareValid_ff <= 1'b0;
			end else if (inValid && !spareValid_ff) begin
				spareValid_ff <= 1'b1;
				spare_ff <= inData;
			end
		end
	end
endmodule

// File: rtl/vla_luma_adjust.sv
/*
 * Luma adjust block: register bank reached over APB and the luma path
 * that applies contrast gain and brightness offset with saturation,
 * tagging every sample with the control copy of its field.
 * Assumes samples come from logic on clk with valid/ready handshake,
 * and an APB master on the same clock.
 */
module vla_luma_adjust
	import vla_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sample input
	input wire logic sampleValid,
	output logic sampleReady,
	input wire vla_in_t sampleIn,
	// sample output
	output logic pixValid,
	input wire logic pixReady,
	output vla_pix_t pixOut
);
	// register bank
	logic [7:0] lumaOffset_ff;
	logic [7:0] ctrlEven_ff;
	logic [7:0] ctrlOdd_ff;
	logic [7:0] gainLow_ff;
	logic clipHigh_ff;
	logic clipLow_ff;
	logic lastOdd_ff;
	logic [15:0] sampleCount_ff;

	// apb state
	logic [31:0] prdata_ff;
	logic rdLoaded_ff;
	logic decodeHit;
	logic busWrite;
	logic [31:0] nxt_rdata;

	// pipeline stage one
	logic stValid_ff;
	logic [16:0] stProd_ff;
	logic [7:0] stOffset_ff;
	logic stOdd_ff;
	vla_ctrl_t stCtrl_ff;
	logic stAdvance;

	// stage two result
	logic [30:0] scaleWide;
	logic [10:0] scaled;
	logic signed [11:0] lumaSum;
	logic [7:0] lumaSat;
	logic overHigh;
	logic underLow;
	vla_pix_t stResult;
	logic bufReady;
	logic pixTaken;

	// selected field controls
	logic [7:0] fieldCtrl;
	vla_ctrl_t nxt_ctrl;

	// true when the address hits a mapped register
	function automatic logic addrHit(input logic [11:0] a);
		unique case (a)
			`VLA_ADDR_LUMA_OFFSET,
			`VLA_ADDR_CTRL_EVEN,
			`VLA_ADDR_GAIN_LOW,
			`VLA_ADDR_CTRL_ODD,
			`VLA_ADDR_STATUS,
			`VLA_ADDR_SAMPLE_COUNT: addrHit = 1'b1;
			default: addrHit = 1'b0;
		endcase
	endfunction

	// clamp a signed sum into the eight-bit luma range
	function automatic logic [7:0] sat8(input logic signed [11:0] v);
		if (v < 12'sh000) begin
			sat8 = 8'h00;
		end else if (v > 12'sh0FF) begin
			sat8 = 8'hFF;
		end else begin
			sat8 = v[7:0];
		end
	endfunction

	// apb decode and handshakes
	assign decodeHit = addrHit(paddr);
	assign pready = psel & penable & rdLoaded_ff & ce;
	assign pslverr = pready & ~decodeHit;
	assign busWrite = pready & pwrite & decodeHit & pstrb[0];
	assign prdata = prdata_ff;

	// read data mux, upper bits read as zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (paddr)
			`VLA_ADDR_LUMA_OFFSET: nxt_rdata[7:0] = lumaOffset_ff;
			`VLA_ADDR_CTRL_EVEN: nxt_rdata[7:0] = ctrlEven_ff;
			`VLA_ADDR_GAIN_LOW: nxt_rdata[7:0] = gainLow_ff;
			`VLA_ADDR_CTRL_ODD: nxt_rdata[7:0] = ctrlOdd_ff;
			`VLA_ADDR_STATUS: begin
				nxt_rdata[`VLA_BIT_ST_CLIP_HIGH] = clipHigh_ff;
				nxt_rdata[`VLA_BIT_ST_CLIP_LOW] = clipLow_ff;
				nxt_rdata[`VLA_BIT_ST_LAST_ODD] = lastOdd_ff;
				nxt_rdata[`VLA_BIT_ST_BUSY] = stValid_ff | pixValid;
			end
			`VLA_ADDR_SAMPLE_COUNT: nxt_rdata[15:0] = sampleCount_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read data captured in setup, ready one cycle later
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdLoaded_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (ce) begin
			if (pready) begin
				rdLoaded_ff <= 1'b0;
			end else if (psel && !rdLoaded_ff) begin
				rdLoaded_ff <= 1'b1;
				prdata_ff <= nxt_rdata;
			end
		end
	end

	// brightness offset register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lumaOffset_ff <= `VLA_RST_LUMA_OFFSET;
		end else if (ce && busWrite && paddr == `VLA_ADDR_LUMA_OFFSET) begin
			lumaOffset_ff <= pwdata[7:0];
		end
	end

	// per-field control copies, reserved bit stored as written
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlEven_ff <= `VLA_RST_CTRL;
			ctrlOdd_ff <= `VLA_RST_CTRL;
		end else if (ce && busWrite) begin
			if (paddr == `VLA_ADDR_CTRL_EVEN) begin
				ctrlEven_ff <= pwdata[7:0];
			end
			if (paddr == `VLA_ADDR_CTRL_ODD) begin
				ctrlOdd_ff <= pwdata[7:0];
			end
		end
	end

	// contrast low byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gainLow_ff <= `VLA_RST_GAIN_LOW;
		end else if (ce && busWrite && paddr == `VLA_ADDR_GAIN_LOW) begin
			gainLow_ff <= pwdata[7:0];
		end
	end

	// control copy chosen by the sample's field
	assign fieldCtrl = sampleIn.oddField ? ctrlOdd_ff : ctrlEven_ff;

	// decode control bits into the outgoing bundle
	always_comb begin
		nxt_ctrl.notchBypass = fieldCtrl[`VLA_BIT_NOTCH_BYPASS]
			| fieldCtrl[`VLA_BIT_YC_MODE];
		nxt_ctrl.ycMode = fieldCtrl[`VLA_BIT_YC_MODE];
		nxt_ctrl.decimBypass = fieldCtrl[`VLA_BIT_DECIM_BYPASS];
		nxt_ctrl.chromaInvert = fieldCtrl[`VLA_BIT_CHROMA_INVERT];
		nxt_ctrl.firstIsCr = fieldCtrl[`VLA_BIT_CHROMA_INVERT] ^ sampleIn.hStartOdd;
		nxt_ctrl.uGainTop = fieldCtrl[`VLA_BIT_U_GAIN_TOP];
		nxt_ctrl.vGainTop = fieldCtrl[`VLA_BIT_V_GAIN_TOP];
	end

	// stage one moves when empty or when the buffer takes its word
	assign stAdvance = ~stValid_ff | bufReady;
	assign sampleReady = ce & stAdvance;

	// stage one: gain product and snapshot of field settings
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stValid_ff <= 1'b0;
			stProd_ff <= 17'h0_0000;
			stOffset_ff <= 8'h00;
			stOdd_ff <= 1'b0;
			stCtrl_ff <= '0;
		end else if (ce && stAdvance) begin
			stValid_ff <= sampleValid;
			if (sampleValid) begin
				stProd_ff <= sampleIn.luma * {fieldCtrl[`VLA_BIT_GAIN_TOP], gainLow_ff};
				stOffset_ff <= lumaOffset_ff;
				stOdd_ff <= sampleIn.oddField;
				stCtrl_ff <= nxt_ctrl;
			end
		end
	end

	// stage two: unity at 216, then signed offset and clamp
	always_comb begin
		scaleWide = 31'(stProd_ff) * 31'(`VLA_GAIN_RECIP) + `VLA_GAIN_ROUND;
		scaled = scaleWide[30:`VLA_GAIN_SHIFT];
		lumaSum = $signed({1'b0, scaled}) + 12'(signed'(stOffset_ff));
		lumaSat = sat8(lumaSum);
		overHigh = lumaSum > 12'sh0FF;
		underLow = lumaSum < 12'sh000;
		stResult.luma = lumaSat;
		stResult.oddField = stOdd_ff;
		stResult.ctrl = stCtrl_ff;
	end

	// output buffer absorbs receiver stalls
	vla_buf2 outBuf (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.inValid(stValid_ff),
		.inReady(bufReady),
		.inData(stResult),
		.outValid(pixValid),
		.outReady(pixReady),
		.outData(pixOut)
	);

	assign pixTaken = pixValid & pixReady;

	// sticky clip flags, set wins over write-one-clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clipHigh_ff <= 1'b0;
			clipLow_ff <= 1'b0;
		end else if (ce) begin
			if (stValid_ff && bufReady && overHigh) begin
				clipHigh_ff <= 1'b1;
			end else if (busWrite && paddr == `VLA_ADDR_STATUS && pwdata[`VLA_BIT_ST_CLIP_HIGH]) begin
				clipHigh_ff <= 1'b0;
			end
			if (stValid_ff && bufReady && underLow) begin
				clipLow_ff <= 1'b1;
			end else if (busWrite && paddr == `VLA_ADDR_STATUS && pwdata[`VLA_BIT_ST_CLIP_LOW]) begin
				clipLow_ff <= 1'b0;
			end
		end
	end

	// delivered sample count and last field seen, increment wins over clearing write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sampleCount_ff <= 16'h0000;
			lastOdd_ff <= 1'b0;
		end else if (ce) begin
			if (pixTaken) begin
				sampleCount_ff <= sampleCount_ff + 16'h0001;
				lastOdd_ff <= pixOut.oddField;
			end else if (busWrite && paddr == `VLA_ADDR_SAMPLE_COUNT) begin
				sampleCount_ff <= 16'h0000;
			end
		end
	end
endmodule

// File: verification/vla_luma_adjust_monitor.sv
/* port assertions of the luma adjust block.
   assumes bind onto vla_luma_adjust, one clock, async low reset. */
module vla_luma_adjust_monitor
	import vla_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// samples
	input wire logic sampleValid,
	input wire logic sampleReady,
	input wire vla_in_t sampleIn,
	input wire logic pixValid,
	input wire logic pixReady,
	input wire vla_pix_t pixOut
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// register map decode
	wire logic mapped = paddr inside {12'h028, 12'h02C, 12'h030, 12'h0AC, 12'h0F0, 12'h0F4};
	// apb phases and sample intake
	sequence setup_s;
		psel && !penable && ce;
	endsequence
	sequence access_s;
		psel && penable && ce;
	endsequence
	sequence taken_s;
		sampleValid && sampleReady ##1 ce ##1 ce;
	endsequence
	zero_wait_a: assert property (setup_s ##1 access_s |-> pready)
		else $error("access not answered at once");
	reg_decode_a: assert property (pready |-> pslverr == !mapped)
		else $error("slave error disagrees with map");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("slave error outside access");
	upper_zero_a: assert property (pready && !pwrite && paddr != 12'h0F4 |-> prdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	out_latency_a: assert property (taken_s |-> pixValid)
		else $error("sample not delivered in two cycles");
	hold_out_a: assert property (pixValid && !pixReady ##1 ce |-> pixValid && $stable(pixOut))
		else $error("stalled output changed");
	notch_forced_a: assert property (pixValid && pixOut.ctrl.ycMode |-> pixOut.ctrl.notchBypass)
		else $error("notch not bypassed in yc mode");
	freeze_a: assert property (!ce |-> !pready && !sampleReady && !pixValid)
		else $error("activity while clock enable low");
endmodule
bind vla_luma_adjust vla_luma_adjust_monitor vla_luma_adjust_monitor_i (.clk, .reset_n, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sampleValid,
	.sampleReady, .sampleIn, .pixValid, .pixReady, .pixOut);

// File: verification/vla_luma_adjust_test.sv
/* register and sample tests of the luma adjust block.
   assumes design and monitor compiled first. */
module vla_luma_adjust_test import vla_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, ce, psel, penable, pwrite, sampleValid, pixReady;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, sampleReady, pixValid, e;
	vla_in_t sampleIn;
	vla_pix_t pixOut;
	vla_pix_t expQ[$];
	int error_cnt, samples_checked, cyc;
	logic [11:0] adr[4] = '{12'h028, 12'h02C, 12'h030, 12'h0AC};
	logic [7:0] rv[4] = '{8'h00, 8'h20, 8'hD8, 8'h20};
	logic [7:0] lum[4] = '{8'h00, 8'h32, 8'hC8, 8'hFF};

	vla_luma_adjust vla_luma_adjust_i (.clk, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'h1), .prdata, .pready, .pslverr, .sampleValid, .sampleReady, .sampleIn, .pixValid,
		.pixReady, .pixOut);

	// clock
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end

	// run length bound
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// receiver compares each delivered sample
	always @(posedge clk) begin
		if (pixValid === 1'b1 && pixReady === 1'b1)
			chk({16'h0, pixOut}, {16'h0, expQ.pop_front()});
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer held until pready, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask

	task automatic chkRegs();
		for (int i = 0; i < 4; i++) begin
			apb(0, adr[i], 32'h0);
			chk(q, {24'h0, rv[i]});
		end
	endtask

	// bytes: offset, even ctrl, gain low, odd ctrl
	task automatic setRegs(input logic [31:0] p);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			rv[i] = p[8*i +: 8];
			apb(1, adr[i], {24'h0, rv[i]});
		end
		chkRegs();
	endtask

	// expected sample from shadow registers
	function automatic vla_pix_t model(input logic [7:0] l, input logic o, input logic h);
		logic [7:0] c;
		int v;
		c = o ? rv[3] : rv[1];
		v = (int'(l) * int'({c[2], rv[2]}) * 4855 + 524288) >>> 20;
		v = v + int'($signed(rv[0]));
		v = v < 0 ? 0 : (v > 255 ? 255 : v);
		return {v[7:0], o, c[7] | c[6], c[6], c[5], c[4], c[4] ^ h, c[1], c[0]};
	endfunction

	task automatic push(input logic [7:0] l, input logic o, input logic h);
		int n;
		n = 0;
		sampleValid <= 1;
		sampleIn <= {l, o, h};
		do begin
			@(posedge clk);
			n++;
		end while (sampleReady !== 1'b1 && n < 50);
		expQ.push_back(model(l, o, h));
	endtask

	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, sampleValid, sampleIn} = '0;
		ce = 1;
		pixReady = 1;
		repeat (8) @(posedge clk);
		reset_n <= 1;
		chkRegs();
		apb(0, 12'h040, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		setRegs(32'h40D8_9780);
		for (int i = 0; i < 8; i++)
			push(lum[i % 4], i[0], i[1]);
		sampleValid <= 0;
		setRegs(32'h2410_307F);
		for (int i = 0; i < 8; i++)
			push(lum[i % 4], i[0], i[1]);
		sampleValid <= 0;
		repeat (6) @(posedge clk);
		// fill the pipe with the receiver stalled
		pixReady <= 0;
		for (int i = 0; i < 3; i++)
			push(lum[i], 1'b1, 1'b0);
		@(posedge clk);
		chk({31'h0, sampleReady}, 32'h0);
		sampleValid <= 0;
		ce <= 0;
		repeat (3) @(posedge clk);
		ce <= 1;
		pixReady <= 1;
		repeat (10) @(posedge clk);
		chk(expQ.size(), 32'h0);
		report_and_stop();
	end
endmodule
